// file: sim/dados_capture.sv
// Capture-side model: takes bus data on both forwarded clock edges
`timescale 1ns/1ns
module dados_capture (
    input  wire logic [dados_pkg::SAMPLE_W-1:0] data_bus,  // Bus data
    input  wire logic                           fwd_clock, // Forwarded DDR clock
    output logic [dados_pkg::SAMPLE_W-1:0]      captured   // Last word taken
);
    initial captured = 12'h000;
    // Either edge captures, so edge selection alone cannot starve it
    always @(fwd_clock) captured <= data_bus;
endmodule

// file: sim/dados_top_bench.sv
// Bench: AXI4-Lite register access and output pin checks
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dados_top_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, chip_enable = 1'b0, config_reset_n = 1'b1;
    logic        sclk = 1'b0, serial_frame_enable_n = 1'b1, sdio_in = 1'b0;
    logic        align_reset_in = 1'b0, adc_a_over = 1'b0, adc_b_over = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [11:0] adc_a_sample = 12'h000, adc_b_sample = 12'h000;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, oe_v;
    logic [31:0] s_axi_rdata, rd_v;
    logic        sdio_out, sdio_oe, serial_data_out, serial_data_out_oe, multi_device_align_out;
    logic        chan_a_fwd_clock, chan_b_fwd_clock, chan_a_overrange_flag, chan_b_overrange_flag;
    logic [11:0] chan_a_data_bus, chan_b_data_bus, cap_a, cap_b;
    int          error_cnt = 0, checked = 0;

    dados_top #(.SYNC_PERIOD(2)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_enable, .config_reset_n,
        .sclk, .serial_frame_enable_n, .sdio_in, .sdio_out, .sdio_oe, .serial_data_out,
        .serial_data_out_oe, .align_reset_in, .adc_a_sample, .adc_b_sample, .adc_a_over,
        .adc_b_over, .chan_a_data_bus, .chan_b_data_bus, .chan_a_fwd_clock, .chan_b_fwd_clock,
        .multi_device_align_out, .chan_a_overrange_flag, .chan_b_overrange_flag, .irq);
    dados_capture cap_a_i (.data_bus(chan_a_data_bus), .fwd_clock(chan_a_fwd_clock),
        .captured(cap_a));
    dados_capture cap_b_i (.data_bus(chan_b_data_bus), .fwd_clock(chan_b_fwd_clock),
        .captured(cap_b));

    initial forever #20 aclk = ~aclk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic ser(input logic [39:0] f, output logic [31:0] r, output logic [1:0] oe);
        serial_frame_enable_n <= 1'b0;
        for (int i = 39; i >= 0; i--) begin
            sdio_in <= f[i];
            repeat (5) @(posedge aclk);
            // Released pins read low
            r = {r[30:0], (sdio_out & sdio_oe) | (serial_data_out & serial_data_out_oe)};
            oe = {serial_data_out_oe, sdio_oe};
            sclk <= 1'b1;
            repeat (5) @(posedge aclk);
            sclk <= 1'b0;
        end
        serial_frame_enable_n <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask

    task automatic end_of_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdr(dados_pkg::ADDR_CONFIG);
        `CHK("cfg", dados_pkg::CONFIG_RESET, s_axi_rdata)
        rdr(8'hFC);
        `CHK("unmapped", dados_pkg::RESP_SLVERR, s_axi_rresp)
        $display("registers done");
        chip_enable <= 1'b1;
        adc_a_sample <= 12'hA5C;
        adc_b_sample <= 12'h3C5;
        repeat (12) @(posedge aclk);
        `CHK("bus_a", 12'hA5C, chan_a_data_bus)
        `CHK("bus_b", 12'h3C5, chan_b_data_bus)
        `CHK("cap_a", 12'hA5C, cap_a)
        `CHK("cap_b", 12'h3C5, cap_b)
        `CHK("sdo_oe", 1'b0, serial_data_out_oe)
        $display("data path done");
        adc_a_over <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK("ovr_a", 1'b1, chan_a_overrange_flag)
        `CHK("ovr_b", 1'b0, chan_b_overrange_flag)
        `CHK("irq_masked", 1'b0, irq)
        adc_a_over <= 1'b0;
        wr(dados_pkg::ADDR_IRQ_EN, 32'h0000_0001);
        `CHK("bresp", dados_pkg::RESP_OKAY, s_axi_bresp)
        repeat (2) @(posedge aclk);
        `CHK("irq_on", 1'b1, irq)
        rdr(dados_pkg::ADDR_IRQ_STAT);
        `CHK("sticky", 32'h0000_0001, s_axi_rdata)
        wr(dados_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        `CHK("irq_off", 1'b0, irq)
        $display("overrange done");
        ser({8'h83, 32'h0000_0000}, rd_v, oe_v);
        `CHK("ser_rd", 32'h0000_0001, rd_v)
        `CHK("sdio_oe", 2'h1, oe_v)
        ser({8'h00, 32'h0001_0018}, rd_v, oe_v);
        ser({8'h80, 32'h0000_0000}, rd_v, oe_v);
        `CHK("ser_cfg", 32'h0001_0018, rd_v)
        `CHK("sdo_oe", 2'h2, oe_v)
        align_reset_in <= 1'b1;
        @(posedge aclk);
        align_reset_in <= 1'b0;
        repeat (2) @(posedge aclk);
        rdr(dados_pkg::ADDR_STATUS);
        `CHK("sync_on", 32'h0000_0003, s_axi_rdata)
        config_reset_n <= 1'b0;
        @(posedge aclk);
        config_reset_n <= 1'b1;
        rdr(dados_pkg::ADDR_CONFIG);
        `CHK("cfg_clr", dados_pkg::CONFIG_RESET, s_axi_rdata)
        $display("serial and align done");
        wr(dados_pkg::ADDR_CONFIG, 32'h0000_0001);
        repeat (6) @(posedge aclk);
        `CHK("pd_bus_a", 12'h000, chan_a_data_bus)
        $display("power down done");
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        end_of_test();
    end
endmodule

// file: verilog/dados_pkg.sv
// Constants, register map and carrier types for the converter pin-level block
package dados_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          SAMPLE_W       = 12;
    localparam int          IRQ_W          = 3;
    localparam int          SER_INSTR_BITS = 8;
    localparam int          SER_DATA_BITS  = 32;
    localparam int          SER_FRAME_BITS = SER_INSTR_BITS + SER_DATA_BITS;
    localparam int          SYNC_PERIOD    = 16;

    localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_EN    = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h10;

    // Config word bit positions
    localparam int          CFG_POWER_DOWN = 0;
    localparam int          CFG_A_FALL     = 1;
    localparam int          CFG_B_FALL     = 2;
    localparam int          CFG_B_ON_A     = 3;
    localparam int          CFG_SYNC_DIS   = 4;
    localparam int          CFG_OVR_A_SYNC = 5;
    localparam int          CFG_OVR_B_SYNC = 6;
    localparam int          CFG_FOUR_WIRE  = 16;

    // Status and interrupt bit positions
    localparam int          ST_RUNNING     = 0;
    localparam int          ST_SYNC_ACTIVE = 1;
    localparam int          ST_OVR_A       = 2;
    localparam int          ST_OVR_B       = 3;
    localparam int          IRQ_OVR_A      = 0;
    localparam int          IRQ_OVR_B      = 1;
    localparam int          IRQ_SYNC       = 2;

    localparam logic [31:0] CONFIG_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic four_wire;
        logic ovr_b_sync;
        logic ovr_a_sync;
        logic sync_dis;
        logic b_on_a;
        logic b_fall;
        logic a_fall;
        logic power_down;
    } dados_cfg_s;

    function automatic dados_cfg_s word_to_cfg(input logic [31:0] w);
        return '{w[CFG_FOUR_WIRE], w[CFG_OVR_B_SYNC], w[CFG_OVR_A_SYNC], w[CFG_SYNC_DIS],
                 w[CFG_B_ON_A], w[CFG_B_FALL], w[CFG_A_FALL], w[CFG_POWER_DOWN]};
    endfunction

    function automatic logic [31:0] cfg_to_word(input dados_cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CFG_FOUR_WIRE]  = c.four_wire;
        w[CFG_OVR_B_SYNC] = c.ovr_b_sync;
        w[CFG_OVR_A_SYNC] = c.ovr_a_sync;
        w[CFG_SYNC_DIS]   = c.sync_dis;
        w[CFG_B_ON_A]     = c.b_on_a;
        w[CFG_B_FALL]     = c.b_fall;
        w[CFG_A_FALL]     = c.a_fall;
        w[CFG_POWER_DOWN] = c.power_down;
        return w;
    endfunction
endpackage

// file: verilog/dados_top.sv
// Converter output pins, serial control port and AXI4-Lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// How it works
// (RULE1) Runs only with enable high, no power-down
// (RULE2) Three-wire mode drives read data on sdio
// (RULE3) Four-wire mode never drives sdio
// (RULE4) Serial out driven only in four-wire mode
// (RULE5) Bus A carries 12-bit sample, DDR
// (RULE6) Bus B carries 12-bit sample, DDR
// (RULE7) Bus A clock forwarded, edge selectable
// (RULE8) Bus B clock forwarded, edge selectable
// (RULE9) Bus B optionally captured with A clock
// (RULE10) Alignment output, disable by config bit
// (RULE11) Bus A overrange flag follows input
// (RULE12) Bus B overrange flag follows input
// (RULE13) Overrange pins may carry alignment output
// (RULE14) Align input high resets dividers, starts output
// (RULE15) Config reset clears configuration asynchronously
// (RULE16) Serial frame held enabled, bits on sclk
module dados_top #(
    parameter int SYNC_PERIOD = dados_pkg::SYNC_PERIOD
) (
    input  wire logic                         aclk,                   // Clock, twice the sample rate
    input  wire logic                         aresetn,                // Sync reset, low
    input  wire logic [dados_pkg::ADDR_W-1:0] s_axi_awaddr,           // AXI write address
    input  wire logic                         s_axi_awvalid,          // AXI
    output logic                              s_axi_awready,          // AXI
    input  wire logic [31:0]                  s_axi_wdata,            // AXI write data
    input  wire logic [3:0]                   s_axi_wstrb,            // AXI byte enables
    input  wire logic                         s_axi_wvalid,           // AXI
    output logic                              s_axi_wready,           // AXI
    output logic [1:0]                        s_axi_bresp,            // AXI
    output logic                              s_axi_bvalid,           // AXI
    input  wire logic                         s_axi_bready,           // AXI
    input  wire logic [dados_pkg::ADDR_W-1:0] s_axi_araddr,           // AXI read address
    input  wire logic                         s_axi_arvalid,          // AXI
    output logic                              s_axi_arready,          // AXI
    output logic [31:0]                       s_axi_rdata,            // AXI read data
    output logic [1:0]                        s_axi_rresp,            // AXI
    output logic                              s_axi_rvalid,           // AXI
    input  wire logic                         s_axi_rready,           // AXI
    input  wire logic                         chip_enable,            // Enable pin, high
    input  wire logic                         config_reset_n,         // Async config reset
    input  wire logic                         sclk,                   // Serial clock pin
    input  wire logic                         serial_frame_enable_n,  // Frame pin, low
    input  wire logic                         sdio_in,                // Serial data pin in
    output logic                              sdio_out,               // Serial data pin out
    output logic                              sdio_oe,                // Serial data pin enable
    output logic                              serial_data_out,        // Serial out pin
    output logic                              serial_data_out_oe,     // Serial out enable
    input  wire logic                         align_reset_in,         // Align input pin
    input  wire logic [dados_pkg::SAMPLE_W-1:0] adc_a_sample,         // Core sample A
    input  wire logic [dados_pkg::SAMPLE_W-1:0] adc_b_sample,         // Core sample B
    input  wire logic                         adc_a_over,             // Core overrange A
    input  wire logic                         adc_b_over,             // Core overrange B
    output logic [dados_pkg::SAMPLE_W-1:0]    chan_a_data_bus,        // Bus A data
    output logic [dados_pkg::SAMPLE_W-1:0]    chan_b_data_bus,        // Bus B data
    output logic                              chan_a_fwd_clock,       // Bus A clock
    output logic                              chan_b_fwd_clock,       // Bus B clock
    output logic                              multi_device_align_out, // Alignment output
    output logic                              chan_a_overrange_flag,  // Bus A overrange
    output logic                              chan_b_overrange_flag,  // Bus B overrange
    output logic                              irq                     // Interrupt, high
);
    initial begin
        if (SYNC_PERIOD < 2 || SYNC_PERIOD > 256) begin
            $error("SYNC_PERIOD out of range");
        end
    end

    // Pin synchronisers
    logic [1:0] en_s, sclk_s, fe_s, sdi_s, al_s;
    logic       sclk_d1_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_s      <= 2'h0;
            sclk_s    <= 2'h0;
            fe_s      <= 2'h3;
            sdi_s     <= 2'h0;
            al_s      <= 2'h0;
            sclk_d1_q <= 1'b0;
        end else begin
            en_s      <= {en_s[0], chip_enable};
            sclk_s    <= {sclk_s[0], sclk};
            fe_s      <= {fe_s[0], serial_frame_enable_n};
            sdi_s     <= {sdi_s[0], sdio_in};
            al_s      <= {al_s[0], align_reset_in};
            sclk_d1_q <= sclk_s[1];
        end
    end

    dados_pkg::dados_cfg_s     cfg_q;
    logic [dados_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q;
    logic                      sync_active_q, ovr_a_q, ovr_b_q, align_prev_q;
    logic                      run_w;
    assign run_w = en_s[1] && !cfg_q.power_down;   // see RULE1

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == dados_pkg::ADDR_CONFIG) begin
            v = dados_pkg::cfg_to_word(cfg_q);
        end else if (a == dados_pkg::ADDR_STATUS) begin
            v[dados_pkg::ST_RUNNING]     = run_w;
            v[dados_pkg::ST_SYNC_ACTIVE] = sync_active_q;
            v[dados_pkg::ST_OVR_A]       = ovr_a_q;
            v[dados_pkg::ST_OVR_B]       = ovr_b_q;
        end else if (a == dados_pkg::ADDR_IRQ_STAT) begin
            v[dados_pkg::IRQ_W-1:0] = irq_stat_q;
        end else if (a == dados_pkg::ADDR_IRQ_EN) begin
            v[dados_pkg::IRQ_W-1:0] = irq_en_q;
        end
        return v;
    endfunction

    // Serial port: 8 instruction bits (read flag, 7-bit word index), 32 data bits
    logic [5:0]  bit_cnt_q;
    logic [7:0]  instr_q;
    logic [31:0] ser_in_q, ser_out_q;
    logic        frame_w, rise_w, fall_w, ser_rd_w, ser_commit_w;
    assign frame_w      = !fe_s[1];
    assign rise_w       = frame_w && sclk_s[1] && !sclk_d1_q;
    assign fall_w       = frame_w && !sclk_s[1] && sclk_d1_q;
    assign ser_rd_w     = instr_q[7];
    assign ser_commit_w = rise_w && !ser_rd_w &&
                          bit_cnt_q == 6'(dados_pkg::SER_FRAME_BITS - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn || !frame_w) begin   // see RULE16
            bit_cnt_q <= 6'h00;
            instr_q   <= 8'h00;
            ser_in_q  <= 32'h0000_0000;
            ser_out_q <= 32'h0000_0000;
        end else begin
            if (rise_w) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
                if (bit_cnt_q < 6'(dados_pkg::SER_INSTR_BITS)) begin
                    instr_q <= {instr_q[6:0], sdi_s[1]};
                end else begin
                    ser_in_q <= {ser_in_q[30:0], sdi_s[1]};
                end
                if (bit_cnt_q == 6'(dados_pkg::SER_INSTR_BITS - 1) && instr_q[6]) begin
                    ser_out_q <= rd_mux({instr_q[4:0], sdi_s[1], 2'h0});
                end
            end
            if (fall_w && bit_cnt_q > 6'(dados_pkg::SER_INSTR_BITS)) begin
                ser_out_q <= {ser_out_q[30:0], 1'b0};
            end
        end
    end

    logic rd_phase_w;
    assign rd_phase_w = frame_w && ser_rd_w && bit_cnt_q >= 6'(dados_pkg::SER_INSTR_BITS);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdio_out           <= 1'b0;
            sdio_oe            <= 1'b0;
            serial_data_out    <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else begin
            sdio_out           <= ser_out_q[31];
            sdio_oe            <= rd_phase_w && !cfg_q.four_wire;  // see RULE2 see RULE3
            serial_data_out    <= ser_out_q[31];
            serial_data_out_oe <= rd_phase_w && cfg_q.four_wire;   // see RULE4
        end
    end

    // AXI4-Lite slave; address and data taken in either order
    logic        aw_full_q, w_full_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q, strb_mask_w, axi_word_w;
    logic [3:0]  w_strb_q;
    logic        aw_take_w, w_take_w, wr_do_w, ar_take_w, rvalid_d, aw_full_d, w_full_d;
    logic        cfg_we_w, en_we_w, clr_we_w, map_ok_w, rmap_ok_w;
    assign aw_take_w   = s_axi_awvalid && s_axi_awready;
    assign w_take_w    = s_axi_wvalid && s_axi_wready;
    // Serial commit wins the shared write port; the AXI write waits one cycle
    assign wr_do_w     = aw_full_q && w_full_q && !s_axi_bvalid && !ser_commit_w;
    assign aw_full_d   = (aw_full_q || aw_take_w) && !wr_do_w;
    assign w_full_d    = (w_full_q || w_take_w) && !wr_do_w;
    assign ar_take_w   = s_axi_arvalid && s_axi_arready;
    assign rvalid_d    = ar_take_w || (s_axi_rvalid && !s_axi_rready);
    assign strb_mask_w = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign axi_word_w  = (dados_pkg::cfg_to_word(cfg_q) & ~strb_mask_w) | (w_data_q & strb_mask_w);
    assign cfg_we_w    = (wr_do_w && aw_addr_q == dados_pkg::ADDR_CONFIG) ||
                         (ser_commit_w && instr_q[6:0] == 7'h00);
    assign en_we_w     = wr_do_w && aw_addr_q == dados_pkg::ADDR_IRQ_EN;
    assign clr_we_w    = wr_do_w && aw_addr_q == dados_pkg::ADDR_IRQ_CLR;
    assign map_ok_w    = aw_addr_q == dados_pkg::ADDR_CONFIG || en_we_w || clr_we_w;
    assign rmap_ok_w   = s_axi_araddr <= dados_pkg::ADDR_IRQ_CLR && s_axi_araddr[1:0] == 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dados_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dados_pkg::RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            if (aw_take_w) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take_w) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_full_d;
            s_axi_wready  <= !w_full_d;
            s_axi_bvalid  <= wr_do_w || (s_axi_bvalid && !s_axi_bready);
            if (wr_do_w) begin
                s_axi_bresp <= map_ok_w ? dados_pkg::RESP_OKAY : dados_pkg::RESP_SLVERR;
            end
            s_axi_arready <= !rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take_w) begin
                s_axi_rdata <= rd_mux(s_axi_araddr);
                s_axi_rresp <= rmap_ok_w ? dados_pkg::RESP_OKAY : dados_pkg::RESP_SLVERR;
            end
        end
    end

    // Configuration; the pin reset acts without the clock
    always_ff @(posedge aclk or negedge config_reset_n) begin
        if (!config_reset_n) begin   // see RULE15
            cfg_q    <= dados_pkg::word_to_cfg(dados_pkg::CONFIG_RESET);
            irq_en_q <= '0;
        end else if (!aresetn) begin
            cfg_q    <= dados_pkg::word_to_cfg(dados_pkg::CONFIG_RESET);
            irq_en_q <= '0;
        end else begin
            if (cfg_we_w) begin
                cfg_q <= dados_pkg::word_to_cfg(ser_commit_w ? ser_in_q << 1 | 32'(sdi_s[1])
                                                              : axi_word_w);
            end
            if (en_we_w) begin
                irq_en_q <= w_data_q[dados_pkg::IRQ_W-1:0];
            end
        end
    end

    // Output path: one sample per two clocks, clock edge mid-window
    logic       phase_q, raw_q, raw_d;
    logic [7:0] sync_cnt_q;
    logic       align_w, align_gen_w;
    assign align_w     = al_s[1];
    assign align_gen_w = sync_active_q && sync_cnt_q == 8'h00;
    assign raw_d       = (run_w && phase_q) ? !raw_q : raw_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 1'b0;
            raw_q   <= 1'b0;
            sync_cnt_q    <= 8'h00;
            sync_active_q <= 1'b0;
            align_prev_q  <= 1'b0;
            ovr_a_q <= 1'b0;
            ovr_b_q <= 1'b0;
            chan_a_data_bus  <= '0;
            chan_b_data_bus  <= '0;
            chan_a_fwd_clock <= 1'b0;
            chan_b_fwd_clock <= 1'b0;
            multi_device_align_out <= 1'b0;
            chan_a_overrange_flag  <= 1'b0;
            chan_b_overrange_flag  <= 1'b0;
        end else begin
            align_prev_q <= align_w;
            if (align_w) begin   // see RULE14
                phase_q       <= 1'b0;
                raw_q         <= 1'b0;
                sync_cnt_q    <= 8'h00;
                sync_active_q <= 1'b1;
            end else if (run_w) begin
                phase_q <= !phase_q;
                raw_q   <= raw_d;
                if (!phase_q) begin
                    sync_cnt_q <= (sync_cnt_q == 8'(SYNC_PERIOD - 1)) ? 8'h00
                                                                      : sync_cnt_q + 8'h01;
                end
            end
            if (!run_w) begin   // see RULE1
                chan_a_data_bus <= '0;
                chan_b_data_bus <= '0;
                ovr_a_q <= 1'b0;
                ovr_b_q <= 1'b0;
            end else if (!phase_q && !align_w) begin
                chan_a_data_bus <= adc_a_sample;   // see RULE5
                chan_b_data_bus <= adc_b_sample;   // see RULE6
                ovr_a_q <= adc_a_over;
                ovr_b_q <= adc_b_over;
            end
            chan_a_fwd_clock <= (align_w ? 1'b0 : raw_d) ^ cfg_q.a_fall;   // see RULE7
            // Shared capture clock: bus B takes bus A edge choice
            chan_b_fwd_clock <= (align_w ? 1'b0 : raw_d) ^
                                (cfg_q.b_on_a ? cfg_q.a_fall : cfg_q.b_fall);   // see RULE8 see RULE9
            multi_device_align_out <= run_w && align_gen_w && !cfg_q.sync_dis;   // see RULE10
            chan_a_overrange_flag <= cfg_q.ovr_a_sync ? (run_w && align_gen_w)   // see RULE13
                                                      : (run_w && adc_a_over);   // see RULE11
            chan_b_overrange_flag <= cfg_q.ovr_b_sync ? (run_w && align_gen_w)
                                                      : (run_w && adc_b_over);   // see RULE12
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    logic [dados_pkg::IRQ_W-1:0] ev_w;
    assign ev_w = {align_w && !align_prev_q, run_w && adc_b_over, run_w && adc_a_over};
    genvar gi;
    generate
        for (gi = 0; gi < dados_pkg::IRQ_W; gi++) begin : g_irq
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (ev_w[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (clr_we_w && w_data_q[gi] && w_strb_q[0]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    sequence s_align_held;
        align_w;
    endsequence
    sequence s_restarted;
        !phase_q && sync_active_q && !chan_a_fwd_clock ^ cfg_q.a_fall;
    endsequence
    property p_off_quiet;
        @(posedge aclk) disable iff (!aresetn) !run_w |=> chan_a_data_bus == '0 && !chan_b_overrange_flag;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("bus active while stopped"); // see RULE1
    property p_sdio_in_only;
        @(posedge aclk) disable iff (!aresetn) cfg_q.four_wire && $past(cfg_q.four_wire) |-> !sdio_oe;
    endproperty
    a_sdio_in_only: assert property (p_sdio_in_only) else $error("sdio driven in 4-wire"); // see RULE3
    property p_sdo_tri;
        @(posedge aclk) disable iff (!aresetn)
            !cfg_q.four_wire && !$past(cfg_q.four_wire) |-> !serial_data_out_oe;
    endproperty
    a_sdo_tri: assert property (p_sdo_tri) else $error("serial out driven in 3-wire"); // see RULE4
    property p_bus_a;
        @(posedge aclk) disable iff (!aresetn)
            run_w && !phase_q && !align_w |=> chan_a_data_bus == $past(adc_a_sample)
            ##1 (!$past(run_w) || $stable(chan_a_data_bus));
    endproperty
    a_bus_a: assert property (p_bus_a) else $error("bus A sample wrong"); // see RULE5
    property p_bus_b;
        @(posedge aclk) disable iff (!aresetn)
            run_w && !phase_q && !align_w |=> chan_b_data_bus == $past(adc_b_sample);
    endproperty
    a_bus_b: assert property (p_bus_b) else $error("bus B sample wrong"); // see RULE6
    property p_clk_mid;
        @(posedge aclk) disable iff (!aresetn)
            run_w && phase_q && !align_w && !$past(cfg_we_w)
            |=> chan_a_fwd_clock != $past(chan_a_fwd_clock);
    endproperty
    a_clk_mid: assert property (p_clk_mid) else $error("bus A clock missed edge"); // see RULE7
    property p_b_on_a;
        @(posedge aclk) disable iff (!aresetn)
            cfg_q.b_on_a && $past(cfg_q.b_on_a) |-> chan_b_fwd_clock == chan_a_fwd_clock;
    endproperty
    a_b_on_a: assert property (p_b_on_a) else $error("bus B clock not on A"); // see RULE9
    property p_sync_dis;
        @(posedge aclk) disable iff (!aresetn) cfg_q.sync_dis && !cfg_we_w |=> !multi_device_align_out;
    endproperty
    a_sync_dis: assert property (p_sync_dis) else $error("align output not disabled"); // see RULE10
    property p_ovr_a;
        @(posedge aclk) disable iff (!aresetn)
            run_w && !cfg_q.ovr_a_sync && !cfg_we_w |=> chan_a_overrange_flag == $past(adc_a_over);
    endproperty
    a_ovr_a: assert property (p_ovr_a) else $error("overrange A wrong"); // see RULE11
    property p_align;
        @(posedge aclk) disable iff (!aresetn) s_align_held |=> s_restarted;
    endproperty
    a_align: assert property (p_align) else $error("align did not restart"); // see RULE14
endmodule
